// ==== hw/efm_pkg.sv ====
// package: register map, field positions and shared types of the far-end monitor
package efm_pkg;
   // ****************************************************
   // register offsets
   // ****************************************************
   localparam logic [15:0] EFM_OFS_CFG  = 16'h1110;
   localparam logic [15:0] EFM_OFS_STAT = 16'h1111;
   localparam logic [15:0] EFM_OFS_IRQ1 = 16'h1114;
   localparam logic [15:0] EFM_OFS_IRQ2 = 16'h1115;
   // ****************************************************
   // field positions
   // ****************************************************
   localparam int EFM_CFG_SEL_BIT   = 4;
   localparam int EFM_CFG_TMF_BIT   = 3;
   localparam int EFM_STAT_LOFA_BIT = 7;
   localparam int EFM_STAT_FEF_BIT  = 0;
   localparam int EFM_IRQ2_FEF_BIT  = 3;
   // ****************************************************
   // reset values, frame counts and interrupt masks
   // ****************************************************
   localparam logic [2:0] EFM_EXP_LABEL_RST = 3'h2;
   localparam logic [2:0] EFM_CNT_SHORT     = 3'h3;
   localparam logic [2:0] EFM_CNT_LONG      = 3'h5;
   localparam logic [7:0] EFM_IRQ1_MASK     = 8'h7f;
   localparam logic [7:0] EFM_IRQ2_MASK     = 8'h5f;

   // ****************************************************
   // types
   // ****************************************************
   typedef enum logic [0:0] {
      EFM_CLEAR,
      EFM_DECLARED
   } efm_state_e;

   // register access strobe from the microprocessor port
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } efm_bus_s;

   // defect flags from the neighbouring receive detectors
   typedef struct packed {
      logic lof;
      logic oof;
      logic los;
      logic ais;
      logic label_unstable;
      logic trail_marker;
   } efm_defects_s;
endpackage : efm_pkg

// ==== hw/efm_monitor.sv ====
// far-end receive failure monitor with its register file
//
// What this block does
// - declare defect after consecutive frames with bit set
// - select zero: declare after three frames
// - select one: declare after five frames
// - count select is writable bit 4, 0x1110
// - declaration sets status bit 0 at 0x1111
// - declared flag stays high, never pulsed
// - declaration sets 0x1115 bit 3, interrupt low
// - 0x1111 layout: algo, defects, label, marker, fef
// - 0x1114 holds seven clear-on-read change flags
// - 0x1115 holds clear-on-read flags, bits 7,5 unused
// - 0x1110 layout: rx label, count select, marker select, expected
// - transmit sends bit set during los, lof, oof or ais
// - clear after three or five zero frames
// - clearing drops flag, sets change, interrupt low
module efm_monitor
   import efm_pkg::*;
#(
   parameter int CNT_W = 3
) (
   // clock, reset, enable
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   // register port
   input  wire efm_bus_s     bus,
   output logic [7:0]        rdata,
   // receive frame stream, one pulse per frame end
   input  wire logic         frame_end,
   input  wire logic         far_end_fail_bit,
   input  wire logic [2:0]   received_payload_label,
   input  wire efm_defects_s defects,
   input  wire logic [6:0]   irq1_events,
   input  wire logic [6:0]   irq2_events,
   // transmit side
   input  wire logic         auto_fef_enable,
   output logic              tx_far_end_fail,
   // interrupt, active low
   output logic              int_n
);
   // ****************************************************
   // configuration registers
   // ****************************************************
   logic       far_end_fail_count_select_r;
   logic       trail_marker_filter_select_r;
   logic [2:0] expected_payload_label_r;
   logic       lof_algo_select_r;
   logic       wr_cfg;
   logic       wr_stat;
   logic       rd_irq1;
   logic       rd_irq2;

   assign wr_cfg  = clk_en && bus.wr && bus.addr == EFM_OFS_CFG;
   assign wr_stat = clk_en && bus.wr && bus.addr == EFM_OFS_STAT;
   assign rd_irq1 = clk_en && bus.rd && bus.addr == EFM_OFS_IRQ1;
   assign rd_irq2 = clk_en && bus.rd && bus.addr == EFM_OFS_IRQ2;

   // writable fields of 0x1110; the received label stays read-only
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         far_end_fail_count_select_r  <= 1'b0;
         trail_marker_filter_select_r <= 1'b0;
         expected_payload_label_r     <= EFM_EXP_LABEL_RST;
      end else if (wr_cfg) begin
         far_end_fail_count_select_r  <= bus.wdata[EFM_CFG_SEL_BIT];
         trail_marker_filter_select_r <= bus.wdata[EFM_CFG_TMF_BIT];
         expected_payload_label_r     <= bus.wdata[2:0];
      end
   end

   // only bit 7 of 0x1111 is writable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         lof_algo_select_r <= 1'b0;
      else if (wr_stat)
         lof_algo_select_r <= bus.wdata[EFM_STAT_LOFA_BIT];
   end

   // ****************************************************
   // consecutive frame counter and defect state
   // ****************************************************
   efm_state_e       state_r;
   logic [CNT_W-1:0] run_r;
   logic [CNT_W-1:0] target;
   logic             opposite;
   logic             change;

   // threshold chosen by the select bit, shared by declare and clear
   function automatic logic [CNT_W-1:0] frames_needed(input logic sel);
      frames_needed = sel ? CNT_W'(EFM_CNT_LONG) : CNT_W'(EFM_CNT_SHORT);
   endfunction

   assign target   = frames_needed(far_end_fail_count_select_r);
   // a frame disagreeing with the current state advances the run
   assign opposite = far_end_fail_bit ^ (state_r == EFM_DECLARED);
   assign change   = clk_en && frame_end && opposite
                     && (run_r + CNT_W'(1) >= target);

   // one agreeing frame breaks the run; the run restarts at zero on reaching target
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         run_r <= '0;
      else if (clk_en && frame_end) begin
         if (!opposite || change)
            run_r <= '0;
         else
            run_r <= run_r + CNT_W'(1);
      end
   end

   // declared level holds until the clearance run completes
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         state_r <= EFM_CLEAR;
      else if (change)
         state_r <= (state_r == EFM_CLEAR) ? EFM_DECLARED : EFM_CLEAR;
   end

   // ****************************************************
   // clear-on-read interrupt status
   // ****************************************************
   logic [7:0] irq1_r;
   logic [7:0] irq2_r;
   logic [7:0] irq2_set;

   assign irq2_set = {1'b0, irq2_events[6], 1'b0, irq2_events[4],
                      change, irq2_events[2:0]};

   // a new event in the read cycle survives the clear
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq1_r <= 8'h00;
         irq2_r <= 8'h00;
      end else if (clk_en) begin
         irq1_r <= ((rd_irq1 ? 8'h00 : irq1_r) | {1'b0, irq1_events})
                   & EFM_IRQ1_MASK;
         irq2_r <= ((rd_irq2 ? 8'h00 : irq2_r) | irq2_set)
                   & EFM_IRQ2_MASK;
      end
   end

   // pin low while any flag is pending
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         int_n <= 1'b1;
      else if (clk_en)
         int_n <= ~(|irq1_r | |irq2_r);
   end

   // ****************************************************
   // read data and transmit insertion
   // ****************************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         rdata <= 8'h00;
      else if (clk_en && bus.rd) begin
         case (bus.addr)
            EFM_OFS_CFG:  rdata <= {received_payload_label,
                                    far_end_fail_count_select_r,
                                    trail_marker_filter_select_r,
                                    expected_payload_label_r};
            EFM_OFS_STAT: rdata <= {lof_algo_select_r, defects.lof,
                                    defects.oof, defects.los, defects.ais,
                                    defects.label_unstable,
                                    defects.trail_marker,
                                    state_r == EFM_DECLARED};
            EFM_OFS_IRQ1: rdata <= irq1_r;
            EFM_OFS_IRQ2: rdata <= irq2_r;
            default:      rdata <= 8'h00;
         endcase
      end
   end

   // remote end learns of local loss while it lasts
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n)
         tx_far_end_fail <= 1'b0;
      else if (clk_en)
         tx_far_end_fail <= auto_fef_enable && (defects.los || defects.lof
                            || defects.oof || defects.ais);
   end

   // ****************************************************
   // checks
   // ****************************************************
   // independent run counters, so the checks do not reuse the design's run
   logic [2:0] ones_seen;
   logic [2:0] zeros_seen;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ones_seen  <= 3'h0;
         zeros_seen <= 3'h0;
      end else if (clk_en && frame_end) begin
         ones_seen  <= far_end_fail_bit ? ((ones_seen == 3'h7) ? ones_seen
                       : ones_seen + 3'h1) : 3'h0;
         zeros_seen <= !far_end_fail_bit ? ((zeros_seen == 3'h7) ? zeros_seen
                       : zeros_seen + 3'h1) : 3'h0;
      end
   end

   chk_declare_short: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && frame_end && far_end_fail_bit && ones_seen == 3'h2
      && !far_end_fail_count_select_r |=> state_r == EFM_DECLARED)
      else $error("not declared after three frames");
   chk_declare_long: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(state_r == EFM_DECLARED) && $past(far_end_fail_count_select_r)
      |-> $past(ones_seen) >= 3'h4)
      else $error("declared before five frames");
   chk_declare_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(state_r == EFM_DECLARED) |-> $past(frame_end && far_end_fail_bit))
      else $error("declared without a frame");
   chk_flag_change: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(state_r) |-> irq2_r[EFM_IRQ2_FEF_BIT])
      else $error("change flag not set");
   chk_int_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(state_r) && clk_en |=> !int_n)
      else $error("interrupt not asserted");
   chk_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_irq2 && !change |=> !irq2_r[EFM_IRQ2_FEF_BIT])
      else $error("flag not cleared by read");
   chk_state_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == EFM_DECLARED && !(frame_end && clk_en)
      |=> state_r == EFM_DECLARED)
      else $error("declared flag pulsed");
   chk_clear_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(state_r == EFM_DECLARED) |-> $past(!far_end_fail_bit)
      && $past(zeros_seen) >= ($past(far_end_fail_count_select_r)
      ? 3'h4 : 3'h2))
      else $error("cleared too early");
   chk_tx_insert: assert property (@(posedge ref_clk) disable iff (!rst_n)
      clk_en && auto_fef_enable && defects.los |=> tx_far_end_fail)
      else $error("far-end bit not inserted");
   chk_sel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_cfg |=> far_end_fail_count_select_r == $past(bus.wdata[4]))
      else $error("select bit not stored");

   cov_declare: cover property (@(posedge ref_clk) $rose(state_r));
   cov_clear:   cover property (@(posedge ref_clk) $fell(state_r));
   cov_long:    cover property (@(posedge ref_clk)
      far_end_fail_count_select_r && $rose(state_r));
   cov_race:    cover property (@(posedge ref_clk) rd_irq2 && change);
endmodule : efm_monitor

// ==== test/efm_remote_term.sv ====
// remote terminal model: sends frames with their far-end failure bit
module efm_remote_term (
   // clock
   input  wire logic ref_clk,
   // frame stream towards the local receiver
   output logic      frame_end,
   output logic      far_end_fail_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   // no frame in flight at time zero
   initial begin
      frame_end = 1'b0;
      far_end_fail_bit = 1'b0;
   end
   // n frames carrying bit b, one frame end every four cycles
   task automatic send(input int n, input logic b);
      for (int i = 0; i < n; i++) begin
         @(negedge ref_clk);
         frame_end = 1'b1;
         far_end_fail_bit = b;
         @(negedge ref_clk);
         frame_end = 1'b0;
         // bit means nothing between frames, so show its inverse there
         far_end_fail_bit = ~b;
         repeat (2) @(negedge ref_clk);
      end
   endtask
endmodule // efm_remote_term

// ==== test/tb.sv ====
// self-checking testbench of the far-end failure monitor
module tb
   import efm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         ref_clk, rst_n, frame_end, fbit, auto_en, tx_fef, int_n;
   logic         clk_en;
   efm_bus_s     bus;
   logic [7:0]   rdata;
   logic [2:0]   rx_label;
   efm_defects_s defects;
   logic [6:0]   irq1_ev, irq2_ev;
   int           n_errors, total_checks;
   // ****************************************************
   // design and far side
   // ****************************************************
   efm_monitor i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
      .bus(bus), .rdata(rdata), .frame_end(frame_end),
      .far_end_fail_bit(fbit), .received_payload_label(rx_label),
      .defects(defects), .irq1_events(irq1_ev), .irq2_events(irq2_ev),
      .auto_fef_enable(auto_en), .tx_far_end_fail(tx_fef), .int_n(int_n));
   efm_remote_term i_far (.ref_clk(ref_clk), .frame_end(frame_end),
      .far_end_fail_bit(fbit));
   // ****************************************************
   // shared tasks
   // ****************************************************
   task automatic check(input logic [7:0] got, exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge ref_clk);
      bus.wr = 1'b0;
   endtask
   // read strobe held one cycle; rdata taken one and a half cycles after the read edge
   task automatic rdc(input logic [15:0] a, input logic [7:0] exp, string w);
      @(negedge ref_clk);
      bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge ref_clk);
      bus.rd = 1'b0;
      @(negedge ref_clk);
      check(rdata, exp, w);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_regs();
      check({7'h00, int_n}, 8'h01, "int idle after reset");
      rdc(EFM_OFS_CFG, 8'ha2, "cfg reset");
      rdc(EFM_OFS_STAT, 8'h00, "status reset");
      rdc(16'h1112, 8'h00, "unmapped");
      wr(EFM_OFS_CFG, 8'hff);
      rdc(EFM_OFS_CFG, 8'hbf, "cfg write");
   endtask
   // declare then clear with run length n; a zero frame breaks a run
   task automatic t_fef(input logic sel, input int n);
      wr(EFM_OFS_CFG, {3'h0, sel, 1'b0, 3'h2});
      i_far.send(n - 1, 1'b1);
      i_far.send(1, 1'b0);
      i_far.send(n - 1, 1'b1);
      rdc(EFM_OFS_STAT, 8'h00, "run too short");
      i_far.send(1, 1'b1);
      rdc(EFM_OFS_STAT, 8'h01, "declared");
      check({7'h00, int_n}, 8'h00, "int on declare");
      rdc(EFM_OFS_IRQ2, 8'h08, "change flag");
      rdc(EFM_OFS_IRQ2, 8'h00, "flag cleared");
      check({7'h00, int_n}, 8'h01, "int released");
      i_far.send(n + 1, 1'b1);
      rdc(EFM_OFS_STAT, 8'h01, "flag holds");
      rdc(EFM_OFS_IRQ2, 8'h00, "no new change");
      i_far.send(n - 1, 1'b0);
      rdc(EFM_OFS_STAT, 8'h01, "clear too short");
      i_far.send(1, 1'b0);
      rdc(EFM_OFS_STAT, 8'h00, "cleared");
      check({7'h00, int_n}, 8'h00, "int on clear");
      rdc(EFM_OFS_IRQ2, 8'h08, "clear change");
   endtask
   task automatic t_events();
      @(negedge ref_clk);
      irq1_ev = 7'h7f;
      irq2_ev = 7'h7f;
      @(negedge ref_clk);
      irq1_ev = 7'h00;
      irq2_ev = 7'h00;
      rdc(EFM_OFS_IRQ1, 8'h7f, "irq1 flags");
      rdc(EFM_OFS_IRQ2, 8'h57, "irq2 flags");
      rdc(EFM_OFS_IRQ1, 8'h00, "irq1 cleared");
      check({7'h00, int_n}, 8'h01, "int idle");
      // an event while the enable is low must leave no flag behind
      @(negedge ref_clk);
      clk_en = 1'b0;
      irq1_ev = 7'h7f;
      @(negedge ref_clk);
      irq1_ev = 7'h00;
      clk_en = 1'b1;
      rdc(EFM_OFS_IRQ1, 8'h00, "frozen event");
   endtask
   task automatic t_status_tx();
      defects = '1;
      auto_en = 1'b1;
      wr(EFM_OFS_STAT, 8'hff);
      rdc(EFM_OFS_STAT, 8'hfe, "status layout");
      check({7'h00, tx_fef}, 8'h01, "tx insert");
      auto_en = 1'b0;
      repeat (2) @(negedge ref_clk);
      check({7'h00, tx_fef}, 8'h00, "tx disabled");
      defects = '0;
      auto_en = 1'b1;
      repeat (2) @(negedge ref_clk);
      check({7'h00, tx_fef}, 8'h00, "tx no defect");
      defects.ais = 1'b1;
      repeat (2) @(negedge ref_clk);
      check({7'h00, tx_fef}, 8'h01, "tx on ais");
      defects = '0;
   endtask
   // ****************************************************
   // clock, watchdog, main sequence
   // ****************************************************
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // whole run is under 10 us; ten times that means a hang
   initial begin
      #100us;
      n_errors++;
      summarize();
   end
   initial begin
      n_errors = 0;
      total_checks = 0;
      rst_n = 1'b0;
      bus = '0;
      rx_label = 3'h5;
      defects = '0;
      irq1_ev = 7'h00;
      irq2_ev = 7'h00;
      auto_en = 1'b0;
      clk_en = 1'b1;
      repeat (4) @(negedge ref_clk);
      rst_n = 1'b1;
      t_regs();
      t_fef(1'b0, 3);
      t_fef(1'b1, 5);
      t_events();
      t_status_tx();
      summarize();
   end
endmodule // tb
